// >>> verif/bridge_cfg_monitor.sv
// Purpose: Port-level checks of the bridge header
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read checks look one cycle after the strobe
`timescale 1ns/1ps
module bridge_cfg_monitor (
  input wire logic       MCLK_IN,
  input wire logic       RESETN_IN,
  input wire logic       CFG_RD_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [7:0] CFG_RDATA_OUT,
  input wire logic       CFG_RVALID_OUT,
  input wire logic       TYPE1_REQ_IN,
  input wire logic       TYPE1_FWD_OUT,
  input wire logic       MASTER_ABORT_OUT,
  input wire logic       IO_REQ_IN,
  input wire logic       IO_FWD_OUT,
  input wire logic       IO_MISS_OUT,
  input wire logic       GRANT_IN,
  input wire logic       FRAME_END_OUT,
  input wire logic       LATENCY_EXPIRED_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  rvalid_timing_a: assert property (CFG_RVALID_OUT == $past(CFG_RD_IN)) else $error("rvalid");
  subclass_val_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h0a |=> CFG_RDATA_OUT == 8'h04) else $error("sub");
  header_val_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h0e |=> CFG_RDATA_OUT == 8'h01) else $error("hdr");
  lat_reserved_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h1b |=> CFG_RDATA_OUT[2:0] == 3'h0) else $error("lat");
  io_nibble_a: assert property (CFG_RD_IN && CFG_ADDR_IN == 8'h1c |=> CFG_RDATA_OUT[3:0] == 4'h0) else $error("io");
  type1_answer_a: assert property (TYPE1_REQ_IN |=> TYPE1_FWD_OUT != MASTER_ABORT_OUT) else $error("type1");
  io_answer_a: assert property (IO_REQ_IN |=> IO_FWD_OUT != IO_MISS_OUT) else $error("io ans");
  frame_end_a: assert property (FRAME_END_OUT |-> LATENCY_EXPIRED_OUT && !$past(GRANT_IN)) else $error("end");
  cover property (TYPE1_REQ_IN ##1 MASTER_ABORT_OUT);
  cover property (IO_REQ_IN ##1 IO_FWD_OUT);
  cover property (FRAME_END_OUT);
endmodule

// >>> verif/pci_master_model.sv
// Purpose: Bridge master side that frames one burst
// Assumes: go_in changes by non-blocking assignment on the falling edge
// Notes:   Drops the frame only when told to end the burst
`timescale 1ns/1ps
module pci_master_model (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic end_in,
  output logic      start_out = 1'b0,
  output logic      active_out = 1'b0
);
  always @(negedge clk_in) begin
    start_out <= go_in;
    if (go_in)
      active_out <= 1'b1;
    else if (end_in)
      active_out <= 1'b0;
  end
endmodule

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the bridge header
// Assumes: Inputs change on the falling clock edge
// Notes:   Latency field of one unit keeps the burst short
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t %h", $time, a); end end
module tb_top;
  logic MCLK_IN = 0, RESETN_IN = 0, CFG_RD_IN = 0, CFG_WR_IN = 0, TYPE1_REQ_IN = 0, IO_REQ_IN = 0;
  logic GRANT_IN = 1, go = 0;
  logic [7:0] CFG_ADDR_IN = 0, CFG_WDATA_IN = 0, TYPE1_BUS_IN = 0;
  logic [15:0] IO_ADDR_IN = 0;
  wire [7:0] CFG_RDATA_OUT;
  wire CFG_RVALID_OUT, TYPE1_FWD_OUT, MASTER_ABORT_OUT, IO_FWD_OUT, IO_MISS_OUT;
  wire FRAME_END_OUT, LATENCY_EXPIRED_OUT, BURST_START_IN, FRAME_ACTIVE_IN;
  int err_total = 0, checks = 0;
  logic [7:0] ad [12] = '{8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20};
  logic [7:0] e1 [12] = '{8'h5a, 8'h04, 8'h06, 8'h00, 8'h01, 8'h00, 8'hff, 8'hff, 8'hf8, 8'hf0, 8'hf0, 8'h00};
  logic [15:0] rv [8] = '{16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h2fff, 16'h3000, 16'h4fff, 16'h5000};
  always #12.5 MCLK_IN = ~MCLK_IN;
  // Non-default revision shows a hardwired value up
  hub_pci_bridge_config_header #(.REVISION(8'h5a)) uut (.*);
  pci_master_model pm (.clk_in(MCLK_IN), .go_in(go), .end_in(FRAME_END_OUT), .start_out(BURST_START_IN),
    .active_out(FRAME_ACTIVE_IN));
  task cfg(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK_IN);
    CFG_WR_IN = wr;
    CFG_RD_IN = !wr;
    CFG_ADDR_IN = a;
    CFG_WDATA_IN = d;
    @(negedge MCLK_IN);
    CFG_WR_IN = 0;
    CFG_RD_IN = 0;
    if (!wr) `CHK(CFG_RVALID_OUT, 1'b1)
  endtask
  task req(input logic io, input logic [15:0] v, input logic hit);
    @(negedge MCLK_IN);
    IO_REQ_IN = io;
    TYPE1_REQ_IN = !io;
    IO_ADDR_IN = v;
    TYPE1_BUS_IN = v[7:0];
    @(negedge MCLK_IN);
    IO_REQ_IN = 0;
    TYPE1_REQ_IN = 0;
    `CHK({IO_FWD_OUT, IO_MISS_OUT, TYPE1_FWD_OUT, MASTER_ABORT_OUT}, io ? {hit, !hit, 2'b00} : {2'b00, hit, !hit})
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge MCLK_IN);
    RESETN_IN = 1;
    for (int i = 0; i < 12; i++) begin
      cfg(0, ad[i], 8'h00);
      `CHK(CFG_RDATA_OUT, i < 6 ? e1[i] : 8'h00)
      cfg(1, ad[i], 8'hff);
    end
    for (int i = 0; i < 12; i++) begin
      cfg(0, ad[i], 8'h00);
      `CHK(CFG_RDATA_OUT, e1[i])
    end
    $display("test registers done");
    cfg(1, 8'h19, 8'h02);
    cfg(1, 8'h1a, 8'h05);
    cfg(1, 8'h1c, 8'h30);
    cfg(1, 8'h1d, 8'h45);
    for (int i = 0; i < 8; i++)
      req(i > 3, rv[i], i == 1 || i == 2 || i == 5 || i == 6);
    $display("test decode done");
    cfg(1, 8'h1b, 8'h0f);
    @(negedge MCLK_IN) go <= 1;
    @(negedge MCLK_IN) go <= 0;
    repeat (9) @(negedge MCLK_IN);
    `CHK(LATENCY_EXPIRED_OUT, 1'b0)
    @(negedge MCLK_IN);
    `CHK({LATENCY_EXPIRED_OUT, FRAME_END_OUT}, 2'b10)
    GRANT_IN = 0;
    @(negedge MCLK_IN);
    `CHK(FRAME_END_OUT, 1'b1)
    $display("test latency done");
    conclude;
  end
  // Whole run is about 116 cycles (under 3 us); this is far beyond it
  initial begin
    #50us;
    err_total++;
    conclude;
  end
endmodule
bind hub_pci_bridge_config_header bridge_cfg_monitor mon (.*);

// >>> verilog/hub_bridge_cfg_regs.vh
// Purpose: Offsets, field positions and fixed values of the bridge configuration header
// Assumes: Byte-wide configuration accesses at the header's byte offsets
// Notes:   Definitions only
`ifndef HUB_BRIDGE_CFG_REGS_VH
`define HUB_BRIDGE_CFG_REGS_VH

`define OFS_REVISION_CODE      8'h08
`define OFS_BRIDGE_SUBCLASS    8'h0a
`define OFS_DEVICE_BASE_CLASS  8'h0b
`define OFS_UPSTREAM_LATENCY   8'h0d
`define OFS_HEADER_LAYOUT      8'h0e
`define OFS_UPSTREAM_BUS       8'h18
`define OFS_DOWNSTREAM_BUS     8'h19
`define OFS_HIGHEST_BUS        8'h1a
`define OFS_DOWNSTREAM_LATENCY 8'h1b
`define OFS_IO_WINDOW_BASE     8'h1c
`define OFS_IO_WINDOW_LIMIT    8'h1d

`define VAL_BRIDGE_SUBCLASS    8'h04
`define VAL_DEVICE_BASE_CLASS  8'h06
`define VAL_UPSTREAM_LATENCY   8'h00
`define VAL_HEADER_LAYOUT      8'h01
`define VAL_UPSTREAM_BUS       8'h00
`define VAL_IO_CAPABILITY      4'h0
`define RST_BUS_NUMBER         8'h00
`define RST_LATENCY_FIELD      5'h00
`define RST_IO_NIBBLE          4'h0

`define LAT_FIELD_MSB          7
`define LAT_FIELD_LSB          3
`define LAT_RESERVED_ZERO      3'h0
`define IO_NIBBLE_MSB          7
`define IO_NIBBLE_LSB          4
`define IO_BASE_PAD            12'h000
`define IO_LIMIT_PAD           12'hfff
`define LAT_UNIT_SHIFT         3
`define RST_OUT_BYTE           8'h00
`define RD_IDLE_BYTE           8'h00
`define RST_COUNTER            8'h00
`define CNT_STEP               8'h01

`endif

// >>> verilog/hub_pci_bridge_config_header.v
// Purpose: Bridge-type configuration header with bus-number, latency and I/O window decode
// Assumes: All inputs come from logic clocked by MCLK_IN; byte-wide config port
// Notes:   Decode and burst-end outputs are registered, one cycle after their cause
`timescale 1ns/1ps
`include "hub_bridge_cfg_regs.vh"

// Overview of operation
// - Read-only revision byte; writes ignored.
// - Sub-class byte reads fixed 04h, a PCI-to-PCI bridge.
// - Base-class byte reads fixed 06h, a bridge device.
// - Upstream latency timer unimplemented; whole byte reads zero.
// - Header type reads 01h: single function, bridge layout.
// - Upstream bus number hardwired read-only to 00h.
// - Writable downstream bus number, reset zero; matching cycles go out as Type 1.
// - Writable highest bus, reset zero; out-of-range Type 1 cycles master-abort upstream.
// - Latency counter loads on granted cycle start, counts down from FRAME# assertion.
// - Counter expired and grant withdrawn: deassert FRAME# to end burst.
// - Counter expired but grant still held: keep bursting.
// - Latency limit is 5-bit field 7:3 in 8-clock units; 2:0 reserved.
// - I/O base bits 15:12 from bits 7:4; low twelve bits are 000h.
// - I/O capability nibble reads 0h: 16-bit I/O decoding only.
// - Separate writable limit gives bits 15:12; low twelve bits are FFFh.
module hub_pci_bridge_config_header #(
  parameter [7:0] REVISION = 8'h01  // Arbitrary value
) (
  input  wire        MCLK_IN,
  input  wire        RESETN_IN,
  input  wire        CFG_RD_IN,
  input  wire        CFG_WR_IN,
  input  wire [7:0]  CFG_ADDR_IN,
  input  wire [7:0]  CFG_WDATA_IN,
  output reg  [7:0]  CFG_RDATA_OUT,
  output reg         CFG_RVALID_OUT,
  input  wire        TYPE1_REQ_IN,
  input  wire [7:0]  TYPE1_BUS_IN,
  output reg         TYPE1_FWD_OUT,
  output reg         MASTER_ABORT_OUT,
  input  wire        IO_REQ_IN,
  input  wire [15:0] IO_ADDR_IN,
  output reg         IO_FWD_OUT,
  output reg         IO_MISS_OUT,
  input  wire        BURST_START_IN,
  input  wire        FRAME_ACTIVE_IN,
  input  wire        GRANT_IN,
  output reg         FRAME_END_OUT,
  output reg         LATENCY_EXPIRED_OUT
);

  // Writable state and the master latency counter
  reg  [7:0]  downstream_bus_number;
  reg  [7:0]  highest_downstream_bus;
  reg  [4:0]  latency_count_field;
  reg  [3:0]  io_base_nibble;
  reg  [3:0]  io_limit_nibble;
  reg  [7:0]  master_latency_counter;

  // Next values of the registered outputs and the latency counter
  reg  [7:0]  next_rdata;
  reg  [7:0]  next_counter;
  reg         next_type1_fwd;
  reg         next_master_abort;
  reg         next_io_fwd;
  reg         next_io_miss;
  reg         next_latency_expired;
  reg         next_frame_end;

  // Read views of the header bytes
  wire [7:0]  revision_code;
  wire [7:0]  bridge_subclass;
  wire [7:0]  device_base_class;
  wire [7:0]  upstream_latency_timer;
  wire [7:0]  header_layout;
  wire [7:0]  upstream_bus_number;
  wire [7:0]  downstream_latency_timer;
  wire [7:0]  io_base_byte;
  wire [7:0]  io_limit_byte;

  // Decode helpers
  wire [15:0] io_window_base;
  wire [15:0] io_window_limit;
  wire [7:0]  latency_load;
  wire        counter_zero;
  wire        frame_counting;
  wire        bus_at_or_above_low;
  wire        bus_at_or_below_high;
  wire        bus_in_range;
  wire        io_at_or_above_base;
  wire        io_at_or_below_limit;
  wire        io_in_window;
  wire        wr_downstream_bus;
  wire        wr_highest_bus;
  wire        wr_latency;
  wire        wr_io_base;
  wire        wr_io_limit;

  assign revision_code            = REVISION;
  assign bridge_subclass          = `VAL_BRIDGE_SUBCLASS;
  assign device_base_class        = `VAL_DEVICE_BASE_CLASS;
  assign upstream_latency_timer   = `VAL_UPSTREAM_LATENCY;
  assign header_layout            = `VAL_HEADER_LAYOUT;
  assign upstream_bus_number      = `VAL_UPSTREAM_BUS;
  // Reserved low bits are not stored, so they always read zero
  assign downstream_latency_timer = {latency_count_field, `LAT_RESERVED_ZERO};
  // No 32-bit I/O, so the capability nibble is hardwired
  assign io_base_byte             = {io_base_nibble, `VAL_IO_CAPABILITY};
  assign io_limit_byte            = {io_limit_nibble, `VAL_IO_CAPABILITY};

  assign io_window_base  = {io_base_nibble, `IO_BASE_PAD};
  assign io_window_limit = {io_limit_nibble, `IO_LIMIT_PAD};
  assign latency_load    = {latency_count_field, `LAT_RESERVED_ZERO};
  assign counter_zero    = (master_latency_counter == `RST_COUNTER);
  assign frame_counting  = FRAME_ACTIVE_IN && !BURST_START_IN;

  // A target equal to the downstream bus (bus 0 after reset) lies in range
  assign bus_at_or_above_low  = (TYPE1_BUS_IN >= downstream_bus_number);
  assign bus_at_or_below_high = (TYPE1_BUS_IN <= highest_downstream_bus);
  assign bus_in_range         = bus_at_or_above_low && bus_at_or_below_high;

  // An inverted window (limit below base) forwards nothing
  assign io_at_or_above_base  = (IO_ADDR_IN >= io_window_base);
  assign io_at_or_below_limit = (IO_ADDR_IN <= io_window_limit);
  assign io_in_window         = io_at_or_above_base && io_at_or_below_limit;

  // One write strobe per writable byte; read-only offsets have none
  assign wr_downstream_bus = CFG_WR_IN && (CFG_ADDR_IN == `OFS_DOWNSTREAM_BUS);
  assign wr_highest_bus    = CFG_WR_IN && (CFG_ADDR_IN == `OFS_HIGHEST_BUS);
  assign wr_latency        = CFG_WR_IN && (CFG_ADDR_IN == `OFS_DOWNSTREAM_LATENCY);
  assign wr_io_base        = CFG_WR_IN && (CFG_ADDR_IN == `OFS_IO_WINDOW_BASE);
  assign wr_io_limit       = CFG_WR_IN && (CFG_ADDR_IN == `OFS_IO_WINDOW_LIMIT);

  // Read mux; unmapped offsets read zero
  always @* begin
    next_rdata = `RD_IDLE_BYTE;
    case (CFG_ADDR_IN)
      `OFS_REVISION_CODE: begin
        next_rdata = revision_code;
      end
      `OFS_BRIDGE_SUBCLASS: begin
        next_rdata = bridge_subclass;
      end
      `OFS_DEVICE_BASE_CLASS: begin
        next_rdata = device_base_class;
      end
      `OFS_UPSTREAM_LATENCY: begin
        next_rdata = upstream_latency_timer;
      end
      `OFS_HEADER_LAYOUT: begin
        next_rdata = header_layout;
      end
      `OFS_UPSTREAM_BUS: begin
        next_rdata = upstream_bus_number;
      end
      `OFS_DOWNSTREAM_BUS: begin
        next_rdata = downstream_bus_number;
      end
      `OFS_HIGHEST_BUS: begin
        next_rdata = highest_downstream_bus;
      end
      `OFS_DOWNSTREAM_LATENCY: begin
        next_rdata = downstream_latency_timer;
      end
      `OFS_IO_WINDOW_BASE: begin
        next_rdata = io_base_byte;
      end
      `OFS_IO_WINDOW_LIMIT: begin
        next_rdata = io_limit_byte;
      end
      default: begin
        next_rdata = `RD_IDLE_BYTE;
      end
    endcase
  end

  // Writable fields only; read-only bytes have no write path
  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      downstream_bus_number <= `RST_BUS_NUMBER;
    end else if (wr_downstream_bus) begin
      downstream_bus_number <= CFG_WDATA_IN;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      highest_downstream_bus <= `RST_BUS_NUMBER;
    end else if (wr_highest_bus) begin
      highest_downstream_bus <= CFG_WDATA_IN;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      latency_count_field <= `RST_LATENCY_FIELD;
    end else if (wr_latency) begin
      latency_count_field <= CFG_WDATA_IN[`LAT_FIELD_MSB:`LAT_FIELD_LSB];
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      io_base_nibble <= `RST_IO_NIBBLE;
    end else if (wr_io_base) begin
      io_base_nibble <= CFG_WDATA_IN[`IO_NIBBLE_MSB:`IO_NIBBLE_LSB];
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      io_limit_nibble <= `RST_IO_NIBBLE;
    end else if (wr_io_limit) begin
      io_limit_nibble <= CFG_WDATA_IN[`IO_NIBBLE_MSB:`IO_NIBBLE_LSB];
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      CFG_RVALID_OUT <= 1'b0;
    end else begin
      CFG_RVALID_OUT <= CFG_RD_IN;
    end
  end

  // Data is forced to zero outside the valid cycle
  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      CFG_RDATA_OUT <= `RST_OUT_BYTE;
    end else if (CFG_RD_IN) begin
      CFG_RDATA_OUT <= next_rdata;
    end else begin
      CFG_RDATA_OUT <= `RST_OUT_BYTE;
    end
  end

  // Exactly one of forward or abort answers each Type 1 request
  always @* begin
    next_type1_fwd    = 1'b0;
    next_master_abort = 1'b0;
    if (TYPE1_REQ_IN) begin
      if (bus_in_range) begin
        next_type1_fwd = 1'b1;
      end else begin
        next_master_abort = 1'b1;
      end
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      TYPE1_FWD_OUT <= 1'b0;
    end else begin
      TYPE1_FWD_OUT <= next_type1_fwd;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      MASTER_ABORT_OUT <= 1'b0;
    end else begin
      MASTER_ABORT_OUT <= next_master_abort;
    end
  end

  // Exactly one of forward or miss answers each I/O request
  always @* begin
    next_io_fwd  = 1'b0;
    next_io_miss = 1'b0;
    if (IO_REQ_IN) begin
      if (io_in_window) begin
        next_io_fwd = 1'b1;
      end else begin
        next_io_miss = 1'b1;
      end
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      IO_FWD_OUT <= 1'b0;
    end else begin
      IO_FWD_OUT <= next_io_fwd;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      IO_MISS_OUT <= 1'b0;
    end else begin
      IO_MISS_OUT <= next_io_miss;
    end
  end

  // Counter loads on granted start, then decrements each clock while FRAME# is asserted until it holds at zero
  always @* begin
    next_counter = master_latency_counter;
    if (BURST_START_IN) begin
      next_counter = latency_load;
    end else if (FRAME_ACTIVE_IN && !counter_zero) begin
      next_counter = master_latency_counter - `CNT_STEP;
    end
  end

  // Held grant lets the burst run on past expiry
  always @* begin
    next_latency_expired = 1'b0;
    next_frame_end       = 1'b0;
    if (frame_counting && counter_zero) begin
      next_latency_expired = 1'b1;
      if (!GRANT_IN) begin
        next_frame_end = 1'b1;
      end else begin
        next_frame_end = 1'b0;
      end
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      master_latency_counter <= `RST_COUNTER;
    end else begin
      master_latency_counter <= next_counter;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      LATENCY_EXPIRED_OUT <= 1'b0;
    end else begin
      LATENCY_EXPIRED_OUT <= next_latency_expired;
    end
  end

  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      FRAME_END_OUT <= 1'b0;
    end else begin
      FRAME_END_OUT <= next_frame_end;
    end
  end

endmodule
